// *** core/capw_pkg.sv ***
// Purpose: constants and types for the counter array 8-bit pulse block
// Assumes: APB register access, byte address is four times a register index
// Notes:   state of the block is one packed struct, capw_state_t
package capw_pkg;

	localparam int NCH = 3;

	// printed register indices of the compare bytes, channel 0 in slot 0
	localparam logic [2:0][7:0] IDX_CMP_LO = {8'hEB, 8'hE9, 8'hFB};
	localparam logic [2:0][7:0] IDX_CMP_HI = {8'hEC, 8'hEA, 8'hFC};
	// block-local control and status registers
	localparam logic [7:0] IDX_MODE0    = 8'h10;
	localparam logic [7:0] IDX_PCFG     = 8'h13;
	localparam logic [7:0] IDX_CTRL     = 8'h14;
	localparam logic [7:0] IDX_INT_STAT = 8'h15;
	localparam logic [7:0] IDX_INT_MASK = 8'h16;

	// module mode register fields
	localparam int MODE_PULSE_SEL = 0;
	localparam int MODE_MATCH_EN  = 1;
	localparam int MODE_CMP_EN    = 2;
	localparam int MODE_EVT_FLAG  = 3;
	// pulse config register fields
	localparam int PCFG_CYCLE_LENGTH_SELECT_LSB = 0;
	localparam int PCFG_RELOAD_ACCESS_SELECT     = 5;
	localparam int PCFG_CYCLE_OVERFLOW_FLAG      = 7;
	// control register fields
	localparam int CTRL_RUN       = 0;
	localparam int CTRL_CNT_LSB   = 8;
	// interrupt status bit of the cycle overflow event
	localparam int INT_OVF        = 3;

	localparam logic [2:0]  CYCLE_LENGTH_SELECT_8BIT  = 3'h0;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [7:0]  CNT_WRAP    = 8'hFF;
	localparam logic [15:0] RELOAD_RST  = 16'h0000;

	typedef struct packed {
		logic [7:0]            cnt;       // counter low byte
		logic [2:0][7:0]       cmp_lo;
		logic [2:0][7:0]       cmp_hi;
		logic [2:0][15:0]      reload;    // auto-reload value, wider modes
		logic [2:0]            cmp_en;
		logic [2:0]            pulse_sel;
		logic [2:0]            match_en;
		logic [2:0]            evt_flag;
		logic [2:0]            cycle_length_select;
		logic                  reload_access_select;
		logic                  cycle_overflow_flag;
		logic                  run;
		logic [2:0]            pin;
		logic [3:0]            int_stat;
		logic [3:0]            int_mask;
		logic                  irq;
		logic [31:0]           rdata;
	} capw_state_t;

endpackage

// *** core/capw_pwm8.sv ***
// Purpose: 8-bit pulse mode of a three channel counter array, APB slave
// Assumes: one clock; an enabled counter clock is a cycle with run set
// Notes:   zero wait APB; read data captured in the setup cycle
// What this block does
// - counter low byte equal to compare low byte drives pulse pin high
// - counter low byte overflow drives pulse pin low
// - on wrap FF to 00 a channel in pulse mode copies its high byte into the low byte
// - pulse mode needs comparator enable, pulse select, cycle length 000b
// - with match flag enable, each match sets the channel event flag
// - every low byte overflow sets the cycle overflow flag
// - a write to compare low byte clears comparator enable
// - a write to compare high byte sets comparator enable
// - high fraction is (256 - high byte)/256; zero means always high
// - comparator enable cleared gives a continuously low output
// - reload access select steers compare addresses to the reload value
// - low byte is the live 8-bit compare, high byte its reload value; both reset zero
`timescale 1ns/1ps
module capw_pwm8
	import capw_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// pulse pins and interrupt
	output logic      [2:0]  o_pulse_output_pin,
	output logic             o_irq
);

	capw_state_t q_r;
	capw_state_t q_nxt;

	// bus decode
	logic [7:0] idx;
	logic       aligned;
	logic       setup;
	logic       wr;
	logic       hit;
	logic [2:0] wr_lo;
	logic [2:0] wr_hi;
	logic [2:0] wr_mode;
	logic [2:0] active;
	logic [2:0] match;
	logic [7:0] cnt_inc;
	logic       wrap;
	logic       tick;
	logic [2:0] evt_set;

	// the index is the word address; the compare bytes keep their
	// printed numbers as indices, so software uses four times them
	assign idx     = i_paddr[9:2];
	assign aligned = (i_paddr[31:10] == 22'h0) && (i_paddr[1:0] == 2'h0);
	assign setup   = i_psel && !i_penable;
	assign wr      = i_psel && i_penable && i_pwrite;
	assign tick    = q_r.run;
	assign cnt_inc = q_r.cnt + 8'h01;
	assign wrap    = tick && (q_r.cnt == CNT_WRAP);

	// per channel address match and mode qualification
	always_comb begin
		hit = (idx == IDX_PCFG) || (idx == IDX_CTRL) ||
			(idx == IDX_INT_STAT) || (idx == IDX_INT_MASK);
		for (int c = 0; c < NCH; c++) begin
			wr_lo[c]   = wr && aligned && (idx == IDX_CMP_LO[c]);
			wr_hi[c]   = wr && aligned && (idx == IDX_CMP_HI[c]);
			wr_mode[c] = wr && aligned && (idx == IDX_MODE0 + 8'(c));
			hit = hit || (idx == IDX_CMP_LO[c]) || (idx == IDX_CMP_HI[c]) ||
				(idx == IDX_MODE0 + 8'(c));
			active[c] = q_r.cmp_en[c] && q_r.pulse_sel[c] &&
				(q_r.cycle_length_select == CYCLE_LENGTH_SELECT_8BIT);
			// compare against the next count so high time is 256 - high byte
			match[c]  = tick && active[c] && !wrap &&
				(cnt_inc == q_r.cmp_lo[c]);
			// an event is a match, or the wrap when the high byte is zero
			evt_set[c] = q_r.match_en[c] && (match[c] ||
				(wrap && active[c] && q_r.cmp_hi[c] == BYTE_RESET));
		end
		hit = hit && aligned;
	end

	// next state: counter, pins, flags, registers
	always_comb begin
		q_nxt = q_r;
		if (tick) begin
			q_nxt.cnt = cnt_inc;
		end
		for (int c = 0; c < NCH; c++) begin
			if (!active[c]) begin
				q_nxt.pin[c] = 1'b0;
			end else if (wrap) begin
				q_nxt.cmp_lo[c] = q_r.cmp_hi[c];
				// a zero high byte matches at 00, so the pin never falls
				q_nxt.pin[c] = (q_r.cmp_hi[c] == BYTE_RESET);
			end else if (match[c]) begin
				q_nxt.pin[c] = 1'b1;
			end
			// software clears the event flag by writing zero to it
			if (wr_mode[c]) begin
				q_nxt.pulse_sel[c] = i_pwdata[MODE_PULSE_SEL];
				q_nxt.match_en[c]  = i_pwdata[MODE_MATCH_EN];
				q_nxt.cmp_en[c]    = i_pwdata[MODE_CMP_EN];
				if (!i_pwdata[MODE_EVT_FLAG]) begin
					q_nxt.evt_flag[c] = 1'b0;
				end
			end
			// the enable side effect applies whichever byte reload_access_select exposes
			if (wr_lo[c]) begin
				q_nxt.cmp_en[c] = 1'b0;
				if (q_r.reload_access_select) begin
					q_nxt.reload[c][7:0] = i_pwdata[7:0];
				end else begin
					q_nxt.cmp_lo[c] = i_pwdata[7:0];
				end
			end
			if (wr_hi[c]) begin
				q_nxt.cmp_en[c] = 1'b1;
				if (q_r.reload_access_select) begin
					q_nxt.reload[c][15:8] = i_pwdata[7:0];
				end else begin
					q_nxt.cmp_hi[c] = i_pwdata[7:0];
				end
			end
			// the set wins over a clear in the same cycle; a zero high
			// byte matches at 00, so its event rides on the wrap
			if (evt_set[c]) begin
				q_nxt.evt_flag[c] = 1'b1;
				q_nxt.int_stat[c] = 1'b1;
			end
		end
		// shared config and control
		if (wr && aligned && idx == IDX_PCFG) begin
			q_nxt.cycle_length_select = i_pwdata[PCFG_CYCLE_LENGTH_SELECT_LSB +: 3];
			q_nxt.reload_access_select = i_pwdata[PCFG_RELOAD_ACCESS_SELECT];
			if (!i_pwdata[PCFG_CYCLE_OVERFLOW_FLAG]) begin
				q_nxt.cycle_overflow_flag = 1'b0;
			end
		end
		if (wr && aligned && idx == IDX_CTRL) begin
			q_nxt.run = i_pwdata[CTRL_RUN];
		end
		if (wr && aligned && idx == IDX_INT_MASK) begin
			q_nxt.int_mask = i_pwdata[3:0];
		end
		// write one to clear; an event of the same cycle sets again,
		// the overflow bit is set again just below
		if (wr && aligned && idx == IDX_INT_STAT) begin
			q_nxt.int_stat      = q_nxt.int_stat & ~i_pwdata[3:0];
			q_nxt.int_stat[2:0] = q_nxt.int_stat[2:0] | evt_set;
		end
		if (wrap) begin
			q_nxt.cycle_overflow_flag = 1'b1;
			q_nxt.int_stat[INT_OVF] = 1'b1;
		end
		q_nxt.irq = |(q_nxt.int_stat & q_nxt.int_mask);
		// read data is captured in the setup cycle, ready in the access cycle
		if (setup) begin
			q_nxt.rdata = 32'h0000_0000;
			for (int c = 0; c < NCH; c++) begin
				if (idx == IDX_CMP_LO[c]) begin
					q_nxt.rdata[7:0] = q_r.reload_access_select ? q_r.reload[c][7:0] :
						q_r.cmp_lo[c];
				end
				if (idx == IDX_CMP_HI[c]) begin
					q_nxt.rdata[7:0] = q_r.reload_access_select ? q_r.reload[c][15:8] :
						q_r.cmp_hi[c];
				end
				if (idx == IDX_MODE0 + 8'(c)) begin
					q_nxt.rdata[MODE_PULSE_SEL] = q_r.pulse_sel[c];
					q_nxt.rdata[MODE_MATCH_EN]  = q_r.match_en[c];
					q_nxt.rdata[MODE_CMP_EN]    = q_r.cmp_en[c];
					q_nxt.rdata[MODE_EVT_FLAG]  = q_r.evt_flag[c];
				end
			end
			if (idx == IDX_PCFG) begin
				q_nxt.rdata[PCFG_CYCLE_LENGTH_SELECT_LSB +: 3] = q_r.cycle_length_select;
				q_nxt.rdata[PCFG_RELOAD_ACCESS_SELECT]          = q_r.reload_access_select;
				q_nxt.rdata[PCFG_CYCLE_OVERFLOW_FLAG]           = q_r.cycle_overflow_flag;
			end
			if (idx == IDX_CTRL) begin
				q_nxt.rdata[CTRL_RUN]          = q_r.run;
				q_nxt.rdata[CTRL_CNT_LSB +: 8] = q_r.cnt;
			end
			if (idx == IDX_INT_STAT) begin
				q_nxt.rdata[3:0] = q_r.int_stat;
			end
			if (idx == IDX_INT_MASK) begin
				q_nxt.rdata[3:0] = q_r.int_mask;
			end
			if (!aligned) begin
				q_nxt.rdata = 32'h0000_0000;
			end
		end
	end

	// state register, every field resets to a constant
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q_r          <= '0;
			q_r.cmp_lo   <= {NCH{BYTE_RESET}};
			q_r.cmp_hi   <= {NCH{BYTE_RESET}};
			q_r.reload   <= {NCH{RELOAD_RST}};
		end else begin
			q_r <= q_nxt;
		end
	end

	// zero wait slave; unmapped addresses answer with an error
	assign o_pready           = 1'b1;
	assign o_pslverr          = i_psel && i_penable && !hit;
	assign o_prdata           = q_r.rdata;
	assign o_pulse_output_pin = q_r.pin;
	assign o_irq              = q_r.irq;

	// every assertion below runs on the one clock and rests in reset;
	// checks look one edge ahead, since pins and flags are registered
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// channel 0 carries the ratio checks because its high byte is
	// swept in use; the loop further down repeats the rise and fall rules on
	// every channel so a slip in one lane cannot hide

	// rise at match, hold while high, fall at the wrap
	pin_rise_match_a: assert property (
		match[0] |=> o_pulse_output_pin[0])
		else $error("pin 0 not high after match");

	pin_stays_high_a: assert property (
		o_pulse_output_pin[0] && active[0] && !wrap |=>
		o_pulse_output_pin[0])
		else $error("pin 0 dropped before the wrap");

	pin_fall_wrap_a: assert property (
		wrap && active[0] && q_r.cmp_hi[0] != BYTE_RESET |=>
		!o_pulse_output_pin[0])
		else $error("pin 0 not low after wrap");

	pin_low_stays_a: assert property (
		!o_pulse_output_pin[0] && !match[0] && !wrap |=>
		!o_pulse_output_pin[0])
		else $error("pin 0 rose without a match");

	// the wrap reload, and a byte write, alone move the low byte
	reload_copy_a: assert property (
		wrap && active[0] && !wr_lo[0] |=>
		q_r.cmp_lo[0] == $past(q_r.cmp_hi[0]))
		else $error("compare low byte not reloaded");

	reload_keep_a: assert property (
		!wrap && !wr_lo[0] |=> $stable(q_r.cmp_lo[0]))
		else $error("compare low byte moved between wraps");

	// mode qualification
	mode_gate_a: assert property (
		q_r.cycle_length_select != CYCLE_LENGTH_SELECT_8BIT |=> o_pulse_output_pin == 3'h0)
		else $error("pin high outside 8-bit mode");

	select_gate_a: assert property (
		!q_r.pulse_sel[0] |=> !o_pulse_output_pin[0])
		else $error("pin 0 high without pulse select");

	// flags: the set of a match or a wrap lands on the next edge
	event_flag_set_a: assert property (
		match[0] && q_r.match_en[0] |=>
		q_r.evt_flag[0] && q_r.int_stat[0])
		else $error("event flag not set on match");

	event_quiet_a: assert property (
		!q_r.match_en[1] && !q_r.evt_flag[1] |=> !q_r.evt_flag[1])
		else $error("event flag set with match flag disabled");

	ovf_flag_set_a: assert property (
		wrap |=> q_r.cycle_overflow_flag && q_r.int_stat[INT_OVF])
		else $error("overflow flag not set on wrap");

	ovf_to_zero_a: assert property (
		wrap |=> q_r.cnt == BYTE_RESET)
		else $error("overflow did not land on zero");

	// byte writes and the comparator enable
	lo_write_dis_a: assert property (
		wr_lo[1] |=> !q_r.cmp_en[1] ##1 !o_pulse_output_pin[1])
		else $error("low byte write left comparator enabled");

	hi_write_en_a: assert property (
		wr_hi[0] |=> q_r.cmp_en[0])
		else $error("high byte write did not enable comparator");

	// duty extremes: all high at zero, one count at the top value
	full_duty_a: assert property (
		wrap && active[0] && q_r.cmp_hi[0] == BYTE_RESET |=>
		o_pulse_output_pin[0])
		else $error("zero high byte did not hold pin high");

	short_pulse_a: assert property (
		$rose(o_pulse_output_pin[0]) && q_r.run &&
		q_r.cmp_lo[0] == CNT_WRAP && q_r.cmp_hi[0] != BYTE_RESET |=>
		!o_pulse_output_pin[0])
		else $error("largest high byte gave more than one count");

	disabled_low_a: assert property (
		!q_r.cmp_en[2] |=> !o_pulse_output_pin[2])
		else $error("disabled channel pin not low");

	// reload access steering and the plain byte store
	reload_access_select_steer_a: assert property (
		wr_hi[0] && q_r.reload_access_select |=>
		q_r.reload[0][15:8] == $past(i_pwdata[7:0]) &&
		$stable(q_r.cmp_hi[0]))
		else $error("reload select did not steer write");

	direct_write_a: assert property (
		wr_hi[0] && !q_r.reload_access_select |=>
		q_r.cmp_hi[0] == $past(i_pwdata[7:0]))
		else $error("high byte write not stored");

	// counter stepping
	count_step_a: assert property (
		tick |=> q_r.cnt == $past(cnt_inc))
		else $error("counter did not step by one");

	count_hold_a: assert property (
		!tick |=> $stable(q_r.cnt))
		else $error("counter moved while stopped");

	// sticky flags
	flag_hold_a: assert property (
		q_r.cycle_overflow_flag && !(wr && idx == IDX_PCFG) |=> q_r.cycle_overflow_flag)
		else $error("overflow flag dropped without a clear");

	evt_hold_a: assert property (
		q_r.evt_flag[0] && !wr_mode[0] |=> q_r.evt_flag[0])
		else $error("event flag dropped without a clear");

	evt_clear_a: assert property (
		wr_mode[0] && !i_pwdata[MODE_EVT_FLAG] && !match[0] &&
		!wrap |=> !q_r.evt_flag[0])
		else $error("event flag not cleared by a zero write");

	// the same pin and enable rules on every channel
	for (genvar g = 0; g < NCH; g++) begin : g_chk
		ch_rise_a: assert property (
			match[g] |=> o_pulse_output_pin[g])
			else $error("pin not high after its match");

		ch_fall_a: assert property (
			wrap && active[g] && q_r.cmp_hi[g] != BYTE_RESET |=>
			!o_pulse_output_pin[g])
			else $error("pin not low after the wrap");

		ch_lo_write_a: assert property (
			wr_lo[g] |=> !q_r.cmp_en[g])
			else $error("low byte write left comparator enabled");

		ch_hi_write_a: assert property (
			wr_hi[g] |=> q_r.cmp_en[g])
			else $error("high byte write left comparator disabled");

		ch_off_low_a: assert property (
			!q_r.cmp_en[g] |=> !o_pulse_output_pin[g])
			else $error("pin high with comparator disabled");
	end

	// main scenarios: a match, a wrap, an interrupt, steering, full duty
	cov_match_c: cover property (match[0] ##1 o_pulse_output_pin[0]);
	cov_wrap_c: cover property (wrap && active[1]);
	cov_irq_c: cover property (o_irq);
	cov_reload_access_select_c: cover property (wr_hi[0] && q_r.reload_access_select);
	cov_full_c: cover property (wrap && active[1] &&
		q_r.cmp_hi[1] == BYTE_RESET);

endmodule // capw_pwm8

// *** tb/capw_load.sv ***
// Purpose: load on one pulse pin, measures high time and period
// Assumes: pin sampled on the block clock
// Notes:   passive, figures latch at each falling edge of the pin
`timescale 1ns/1ps
module capw_load (
	// clock, reset and observed pin
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_pin,
	// last complete high time and period, in clocks
	output logic      [8:0] o_high_len,
	output logic      [8:0] o_period
);
	logic [8:0] hi_r;
	logic [8:0] per_r;
	logic       prev_r;

	// a fall closes a period; the first figure after start is partial
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{hi_r, per_r, prev_r, o_high_len, o_period} <= '0;
		end else begin
			prev_r <= i_pin;
			if (prev_r && !i_pin) begin
				o_high_len <= hi_r;
				o_period   <= per_r;
				hi_r       <= 9'h000;
				per_r      <= 9'h001;
			end else begin
				hi_r  <= hi_r + {8'h00, i_pin};
				per_r <= per_r + 9'h001;
			end
		end
	end
endmodule // capw_load

// *** tb/capw_pwm8_tb_top.sv ***
// Purpose: self-checking bench of the 8-bit pulse block over APB
// Assumes: pready may take any number of cycles; the timeout ends a hang
// Notes:   all waits of whole periods follow the 256 clock period
`timescale 1ns/1ps
module capw_pwm8_tb_top;
	import capw_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd;
	logic        prdy;
	logic        perr;
	logic [2:0]  pin;
	logic        irq;
	logic [8:0]  hl [3];
	logic [8:0]  per [3];
	int          errors = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [31:0] rd;
	logic        er;
	logic        any_hi;
	logic        all_hi;

	always #2 clk = ~clk;

	capw_pwm8 capw_pwm8_i (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd),
		.o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
		.o_pulse_output_pin(pin), .o_irq(irq));

	// one load per channel pin
	for (genvar g = 0; g < NCH; g++) begin : g_ld
		capw_load capw_load_i (.i_clk(clk), .i_rst_n(rst_n), .i_pin(pin[g]),
			.o_high_len(hl[g]), .o_period(per[g]));
	end

	task automatic results();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s exp %h seen %h", nm, e, s);
		end
	endtask

	// one APB transfer; a fresh edge first so no signal is set twice
	task automatic apb(input logic w, input logic [7:0] ix,
			input logic [31:0] wd);
		@(posedge clk);
		psel  <= 1'b1;
		pwr   <= w;
		paddr <= {22'h0, ix, 2'b00};
		pwd   <= wd;
		@(posedge clk);
		pen <= 1'b1;
		// any number of wait states; only the bench timeout ends a wait
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] ix, input logic [31:0] m, e);
		apb(1'b0, ix, 32'h0);
		check("reg", rd & m, e);
	endtask

	// watch one channel pin for one period
	task automatic watch(input int ch);
		any_hi = 1'b0;
		all_hi = 1'b1;
		repeat (256) begin
			@(posedge clk);
			any_hi = any_hi | pin[ch];
			all_hi = all_hi & pin[ch];
		end
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			errors++;
			results();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int c = 0; c < NCH; c++) begin
			rdc(IDX_CMP_LO[c], 32'hFF, 32'h00);
			rdc(IDX_CMP_HI[c], 32'hFF, 32'h00);
		end
		apb(1'b0, 8'h30, 32'h0);
		check("slverr", {31'h0, er}, 32'h1);
		apb(1'b1, IDX_MODE0, 32'h7);
		apb(1'b1, IDX_CMP_LO[0], 32'h80);
		rdc(IDX_MODE0, 32'h4, 32'h0);
		apb(1'b1, IDX_CMP_HI[0], 32'h80);
		rdc(IDX_MODE0, 32'h4, 32'h4);
		apb(1'b1, IDX_MODE0 + 8'h1, 32'h1);
		apb(1'b1, IDX_CMP_LO[1], 32'h00);
		apb(1'b1, IDX_CMP_HI[1], 32'h00);
		apb(1'b1, IDX_MODE0 + 8'h2, 32'h7);
		apb(1'b1, IDX_CMP_LO[2], 32'h40);
		// reload access: a compare write must not reach the compare byte
		apb(1'b1, IDX_PCFG, 32'h20);
		apb(1'b1, IDX_CMP_HI[0], 32'h11);
		apb(1'b1, IDX_PCFG, 32'h00);
		rdc(IDX_CMP_HI[0], 32'hFF, 32'h80);
		apb(1'b1, IDX_CTRL, 32'h1);
		repeat (700) @(posedge clk);
		check("high0", {23'h0, hl[0]}, 32'h80);
		check("per0", {23'h0, per[0]}, 32'h100);
		watch(1);
		check("ch1 high", {31'h0, all_hi}, 32'h1);
		watch(2);
		check("ch2 low", {31'h0, any_hi}, 32'h0);
		apb(1'b1, IDX_CMP_HI[0], 32'hFF);
		repeat (800) @(posedge clk);
		check("high0 ff", {23'h0, hl[0]}, 32'h1);
		rdc(IDX_CMP_LO[0], 32'hFF, 32'hFF);
		// stop the count so no new event refills the flags
		apb(1'b1, IDX_CTRL, 32'h0);
		rdc(IDX_MODE0, 32'h8, 32'h8);
		rdc(IDX_PCFG, 32'h80, 32'h80);
		apb(1'b1, IDX_MODE0, 32'hF);
		rdc(IDX_MODE0, 32'hF, 32'hF);
		apb(1'b1, IDX_MODE0, 32'h7);
		rdc(IDX_MODE0, 32'hF, 32'h7);
		apb(1'b1, IDX_PCFG, 32'h80);
		rdc(IDX_PCFG, 32'h80, 32'h80);
		apb(1'b1, IDX_PCFG, 32'h00);
		rdc(IDX_PCFG, 32'h80, 32'h00);
		rdc(IDX_INT_STAT, 32'h9, 32'h9);
		check("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, IDX_INT_MASK, 32'h8);
		repeat (2) @(posedge clk);
		check("irq on", {31'h0, irq}, 32'h1);
		apb(1'b1, IDX_INT_STAT, 32'hF);
		repeat (2) @(posedge clk);
		check("irq off", {31'h0, irq}, 32'h0);
		// wrong cycle length keeps the channel out of pulse mode
		apb(1'b1, IDX_PCFG, 32'h1);
		apb(1'b1, IDX_CTRL, 32'h1);
		watch(0);
		check("cycle_length_select", {31'h0, any_hi}, 32'h0);
		results();
	end
endmodule // capw_pwm8_tb_top
